// >>> ocr_regs.svh
// register offsets, field positions and reset values of the control bank
`ifndef OCR_REGS_SVH
`define OCR_REGS_SVH

`define OCR_GEN_CTRL_ADDR 8'h10
`define OCR_GEN_CTRL_RESET 8'hC0
`define OCR_FIXED_ONES 2'h3
`define OCR_BIT_MAIN_EN 0
`define OCR_BIT_SECOND_EN 1
`define OCR_BIT_SHARED 2
`define OCR_BIT_RAMP_LO 3
`define OCR_BIT_RAMP_HI 4
`define OCR_BIT_PANEL 5
`define OCR_STORED_W 6
`define OCR_LEVEL_W 7
`define OCR_READ_UNMAPPED 8'h00

`endif

// >>> ocr_pkg.sv
// types shared by the output mode control bank
package ocr_pkg;
   typedef enum logic [0:0] {
      OCR_MODE_LED = 1'b0,
      OCR_MODE_PANEL = 1'b1
   } ocr_mode_type;
   typedef enum logic [1:0] {
      OCR_RAMP_0 = 2'b00,
      OCR_RAMP_1 = 2'b01,
      OCR_RAMP_2 = 2'b10,
      OCR_RAMP_3 = 2'b11
   } ocr_ramp_type;
endpackage

// >>> ocr_sink_out.sv
// registered enable and level for one current sink output
`timescale 1ns/1ps
`default_nettype none
`include "ocr_regs.svh"
module ocr_sink_out
   import ocr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic enable_in,
   input wire logic [`OCR_LEVEL_W-1:0] level_in,
   output logic enable_out,
   output logic [`OCR_LEVEL_W-1:0] level_out
);
   logic enable_nxt;
   logic [`OCR_LEVEL_W-1:0] level_nxt;

   // a disabled sink shows level zero so the analog side sees no stale code
   always_comb begin
      enable_nxt = enable_in;
      level_nxt = enable_in ? level_in : '0;
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         enable_out <= 1'b0;
         level_out <= '0;
      end else begin
         enable_out <= enable_nxt;
         level_out <= level_nxt;
      end
   end
endmodule // ocr_sink_out
`default_nettype wire

// >>> ocr_top.sv
// general control register and the output mode decode that it steers
`timescale 1ns/1ps
`default_nettype none
`include "ocr_regs.svh"
// Functional notes
// - bit 0 enables main sink, else off
// - bit 1 enables second sink in independent LED mode, else off
// - bit 2 set: main level drives both
// - bit 2 clear: each sink own level
// - bits 3-4 pick ramp rate, both sinks
// - bit 5 clear: LED mode, headroom regulation while analog on
// - bit 5 set: second output is feedback
// - bits 6-7 read-only, always read 1
// - analog on if main, second or panel
// - shared LED mode: main bit switches both
// - independent LED mode: own enable bits
// - panel mode: second sink always off
module ocr_top
   import ocr_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic WR_EN_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic [`OCR_LEVEL_W-1:0] MAIN_LEVEL_IN,
   input wire logic [`OCR_LEVEL_W-1:0] SECOND_LEVEL_IN,
   output logic [7:0] RDATA_OUT,
   output logic MAIN_SINK_EN_OUT,
   output logic [`OCR_LEVEL_W-1:0] MAIN_LEVEL_OUT,
   output logic SECOND_SINK_EN_OUT,
   output logic [`OCR_LEVEL_W-1:0] SECOND_LEVEL_OUT,
   output logic [1:0] RAMP_RATE_OUT,
   output logic PANEL_MODE_OUT,
   output logic HEADROOM_REG_EN_OUT,
   output logic FEEDBACK_REG_EN_OUT,
   output logic ANALOG_EN_OUT
);
   logic [`OCR_STORED_W-1:0] ctrl_r;
   logic [`OCR_STORED_W-1:0] ctrl_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [1:0] ramp_r;
   logic [1:0] ramp_nxt;
   logic panel_r;
   logic panel_nxt;
   logic headroom_r;
   logic headroom_nxt;
   logic feedback_r;
   logic feedback_nxt;
   logic analog_r;
   logic analog_nxt;
   logic main_en;
   logic second_en;
   logic [`OCR_LEVEL_W-1:0] second_src;
   logic reg_hit;
   logic [7:0] ctrl_view;
   ocr_mode_type mode;

   assign reg_hit = (ADDR_IN == `OCR_GEN_CTRL_ADDR);
   // upper two bits are not stored at all, so no write can clear them
   assign ctrl_view = {`OCR_FIXED_ONES, ctrl_r};
   assign mode = ocr_mode_type'(ctrl_r[`OCR_BIT_PANEL]);

   // register storage and readback
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (WR_EN_IN && reg_hit) begin
         ctrl_nxt = WDATA_IN[`OCR_STORED_W-1:0];
      end
      rdata_nxt = reg_hit ? ctrl_view : `OCR_READ_UNMAPPED;
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         ctrl_r <= `OCR_STORED_W'(`OCR_GEN_CTRL_RESET);
         rdata_r <= `OCR_READ_UNMAPPED;
      end else begin
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // sink enable and level selection from the truth table of modes
   always_comb begin
      main_en = ctrl_r[`OCR_BIT_MAIN_EN];
      second_en = 1'b0;
      second_src = SECOND_LEVEL_IN;
      case (mode)
         OCR_MODE_LED: begin
            if (ctrl_r[`OCR_BIT_SHARED]) begin
               second_en = ctrl_r[`OCR_BIT_MAIN_EN];
               second_src = MAIN_LEVEL_IN;
            end else begin
               second_en = ctrl_r[`OCR_BIT_SECOND_EN];
            end
         end
         OCR_MODE_PANEL: begin
            second_en = 1'b0;
         end
         default: begin
            second_en = 1'b0;
         end
      endcase
   end

   // converter and analog controls
   always_comb begin
      ramp_nxt = {ctrl_r[`OCR_BIT_RAMP_HI], ctrl_r[`OCR_BIT_RAMP_LO]};
      panel_nxt = (mode == OCR_MODE_PANEL);
      analog_nxt = ctrl_r[`OCR_BIT_MAIN_EN] | ctrl_r[`OCR_BIT_SECOND_EN]
                   | ctrl_r[`OCR_BIT_PANEL];
      // headroom is gated by analog enable: a fully off device must not
      // regulate anything; gating here keeps the output a plain flop
      headroom_nxt = (mode == OCR_MODE_LED) & analog_nxt;
      feedback_nxt = (mode == OCR_MODE_PANEL);
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         ramp_r <= 2'h0;
         panel_r <= 1'b0;
         headroom_r <= 1'b0;
         feedback_r <= 1'b0;
         analog_r <= 1'b0;
      end else begin
         ramp_r <= ramp_nxt;
         panel_r <= panel_nxt;
         headroom_r <= headroom_nxt;
         feedback_r <= feedback_nxt;
         analog_r <= analog_nxt;
      end
   end

   ocr_sink_out u_main_sink (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .enable_in(main_en),
      .level_in(MAIN_LEVEL_IN),
      .enable_out(MAIN_SINK_EN_OUT),
      .level_out(MAIN_LEVEL_OUT)
   );

   ocr_sink_out u_second_sink (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .enable_in(second_en),
      .level_in(second_src),
      .enable_out(SECOND_SINK_EN_OUT),
      .level_out(SECOND_LEVEL_OUT)
   );

   assign RDATA_OUT = rdata_r;
   assign RAMP_RATE_OUT = ramp_r;
   assign PANEL_MODE_OUT = panel_r;
   assign HEADROOM_REG_EN_OUT = headroom_r;
   assign FEEDBACK_REG_EN_OUT = feedback_r;
   assign ANALOG_EN_OUT = analog_r;

   sequence s_write_hit;
      WR_EN_IN && reg_hit;
   endsequence

   sequence s_led_shared;
      !ctrl_r[`OCR_BIT_PANEL] && ctrl_r[`OCR_BIT_SHARED];
   endsequence

   property p_main_enable;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      1'b1 |=> MAIN_SINK_EN_OUT == $past(ctrl_r[`OCR_BIT_MAIN_EN]);
   endproperty
   a_main_enable: assert property (p_main_enable)
      else $error("main sink enable does not follow bit 0");

   property p_second_indep;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (!ctrl_r[`OCR_BIT_PANEL] && !ctrl_r[`OCR_BIT_SHARED])
      |=> SECOND_SINK_EN_OUT == $past(ctrl_r[`OCR_BIT_SECOND_EN]);
   endproperty
   a_second_indep: assert property (p_second_indep)
      else $error("independent second sink ignores its own enable");

   property p_shared_level;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      s_led_shared and ctrl_r[`OCR_BIT_MAIN_EN]
      |=> SECOND_SINK_EN_OUT && SECOND_LEVEL_OUT == $past(MAIN_LEVEL_IN);
   endproperty
   a_shared_level: assert property (p_shared_level)
      else $error("shared mode second sink not at main level");

   property p_shared_off;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      s_led_shared and !ctrl_r[`OCR_BIT_MAIN_EN]
      |=> !SECOND_SINK_EN_OUT && !MAIN_SINK_EN_OUT;
   endproperty
   a_shared_off: assert property (p_shared_off)
      else $error("shared mode sinks not off together");

   property p_indep_level;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (!ctrl_r[`OCR_BIT_PANEL] && !ctrl_r[`OCR_BIT_SHARED]
       && ctrl_r[`OCR_BIT_SECOND_EN])
      |=> SECOND_LEVEL_OUT == $past(SECOND_LEVEL_IN);
   endproperty
   a_indep_level: assert property (p_indep_level)
      else $error("independent second level not taken from its own reg");

   property p_ramp;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      s_write_hit |=> ##1 RAMP_RATE_OUT == $past(WDATA_IN[4:3], 2);
   endproperty
   a_ramp: assert property (p_ramp)
      else $error("ramp rate not taken from written bits 4:3");

   property p_panel;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      ctrl_r[`OCR_BIT_PANEL] |=> FEEDBACK_REG_EN_OUT && !SECOND_SINK_EN_OUT
      && !HEADROOM_REG_EN_OUT && ANALOG_EN_OUT;
   endproperty
   a_panel: assert property (p_panel)
      else $error("panel mode decode wrong");

   property p_led_headroom;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (!ctrl_r[`OCR_BIT_PANEL] && ctrl_r[`OCR_BIT_MAIN_EN])
      |=> HEADROOM_REG_EN_OUT && !FEEDBACK_REG_EN_OUT;
   endproperty
   a_led_headroom: assert property (p_led_headroom)
      else $error("LED mode headroom regulation not on");

   property p_analog_off;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      (ctrl_r[2:0] == 3'h0 || ctrl_r[2:0] == 3'h4)
      && !ctrl_r[`OCR_BIT_PANEL] |=> !ANALOG_EN_OUT && !MAIN_SINK_EN_OUT;
   endproperty
   a_analog_off: assert property (p_analog_off)
      else $error("analog on with all enables clear");

   property p_upper_ones;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      s_write_hit ##1 reg_hit |=> RDATA_OUT[7:6] == 2'h3
      && RDATA_OUT[5:0] == $past(WDATA_IN[5:0], 2);
   endproperty
   a_upper_ones: assert property (p_upper_ones)
      else $error("readback upper bits not one or low bits wrong");

   property p_second_bit;
      @(posedge CLK_IN) disable iff (!RST_B_IN)
      s_write_hit ##0 (WDATA_IN[5:1] == 5'h01) |=> ##1 SECOND_SINK_EN_OUT;
   endproperty
   a_second_bit: assert property (p_second_bit)
      else $error("second enable write did not turn sink on");
endmodule // ocr_top
`default_nettype wire

// >>> test_output_mode_control_register.sv
// self-checking bench for the output mode control register bank
`timescale 1ns/1ps
`default_nettype none
`include "ocr_regs.svh"
module test_output_mode_control_register import ocr_pkg::*;;
   logic clk_in, rst_b_in, wr_en, men, sen, pan, hdr, fbk, ana;
   logic [7:0] addr, wdata, rdata;
   logic [6:0] ml, sl, mlo, slo;
   logic [1:0] ramp;
   int err_total = 0;
   int num_checks = 0;
   ocr_top u_ocr_top (.CLK_IN(clk_in), .RST_B_IN(rst_b_in),
      .WR_EN_IN(wr_en), .ADDR_IN(addr), .WDATA_IN(wdata),
      .MAIN_LEVEL_IN(ml), .SECOND_LEVEL_IN(sl), .RDATA_OUT(rdata),
      .MAIN_SINK_EN_OUT(men), .MAIN_LEVEL_OUT(mlo),
      .SECOND_SINK_EN_OUT(sen), .SECOND_LEVEL_OUT(slo),
      .RAMP_RATE_OUT(ramp), .PANEL_MODE_OUT(pan),
      .HEADROOM_REG_EN_OUT(hdr), .FEEDBACK_REG_EN_OUT(fbk),
      .ANALOG_EN_OUT(ana));
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // second sink is off in panel mode; in shared mode it follows main
   function automatic logic f_sec_en(logic [5:0] c);
      return !c[5] && (c[2] ? c[0] : c[1]);
   endfunction
   function automatic logic [6:0] f_sec_lvl(logic [5:0] c);
      return f_sec_en(c) ? (c[2] ? ml : sl) : 7'h00;
   endfunction
   task automatic check_all(logic [5:0] c);
      chk("readback", rdata, {2'b11, c});
      chk("main_en", men, c[0]);
      chk("main_lvl", mlo, c[0] ? ml : 7'h00);
      chk("second_en", sen, f_sec_en(c));
      chk("second_en_mode", sen, f_sec_en(c));
      chk("second_en_indep", sen, f_sec_en(c));
      chk("second_en_panel", sen, f_sec_en(c));
      chk("second_lvl_shared", slo, f_sec_lvl(c));
      chk("second_lvl_indep", slo, f_sec_lvl(c));
      chk("ramp", ramp, c[4:3]);
      chk("headroom", hdr, !c[5] && (c[0] || c[1]));
      chk("panel", pan, c[5]);
      chk("feedback", fbk, c[5]);
      chk("analog", ana, c[0] || c[1] || c[5]);
   endtask
   // leaves the strobe up so back-to-back puts never assign twice per step
   task automatic put(logic [7:0] a, logic [7:0] d);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk_in);
   endtask
   task automatic settle();
      wr_en = 1'b0;
      addr = `OCR_GEN_CTRL_ADDR;
      repeat (2) @(negedge clk_in);
   endtask
   task automatic do_reset();
      rst_b_in = 1'b0;
      repeat (5) @(negedge clk_in);
      check_all_zero();
      rst_b_in = 1'b1;
      settle();
      chk("reset_value", rdata, `OCR_GEN_CTRL_RESET);
      check_all(6'h00);
   endtask
   task automatic check_all_zero();
      chk("rst_rdata", rdata, 8'h00);
      chk("rst_outs", {men, sen, pan, hdr, fbk, ana, ramp}, 8'h00);
      chk("rst_main_lvl", {1'b0, mlo}, 8'h00);
      chk("rst_second_lvl", {1'b0, slo}, 8'h00);
   endtask
   initial begin
      logic [7:0] a, keep;
      wr_en = 1'b0;
      addr = `OCR_GEN_CTRL_ADDR;
      wdata = 8'h00;
      ml = 7'h00;
      sl = 7'h00;
      void'($urandom(49));
      do_reset();
      for (int i = 0; i < 64; i++) begin
         ml = (i % 8 == 0) ? 7'h7F : 7'($urandom);
         sl = (i % 8 == 1) ? 7'h7F : 7'($urandom);
         // odd codes arrive right behind a random write
         if (i % 2 == 1)
            put(`OCR_GEN_CTRL_ADDR, 8'($urandom));
         // random upper bits must not stick
         put(`OCR_GEN_CTRL_ADDR, {2'($urandom), 6'(i)});
         settle();
         check_all(6'(i));
      end
      keep = 8'h00;
      for (int k = 0; k < 8; k++) begin
         a = 8'($urandom);
         if (a == `OCR_GEN_CTRL_ADDR)
            a = 8'h11;
         put(`OCR_GEN_CTRL_ADDR, {2'b00, 6'($urandom)});
         keep = {2'b11, wdata[5:0]};
         put(a, 8'($urandom));
         wr_en = 1'b0;
         repeat (2) @(negedge clk_in);
         chk("unmapped_read", rdata, `OCR_READ_UNMAPPED);
         settle();
         check_all(keep[5:0]);
      end
      // a second reset in mid-run clears the functional bits again
      put(`OCR_GEN_CTRL_ADDR, 8'h3F);
      settle();
      do_reset();
      tally_and_finish();
   end
   initial begin
      #250000;
      err_total++;
      tally_and_finish();
   end
endmodule // test_output_mode_control_register
`default_nettype wire
